// ===== design/sas_sequencer.v
// Contract
// R1: subroutine call shifts every saved return address one level deeper first.
// R2: pushed return address is that of the instruction after the call.
// R3: old counter saved to stack, then counter loads call target.
// R4: return moves every stack entry up, top entry into counter.
// R5: table fetch reads rom byte at pair 0, writes it to the pair selected by opa[3:1].
// R6: table fetch keeps the chip-select part of the address.
// R7: increment-skip increments register, branches if result nonzero, else continues.
// R8: send-register-control drives chosen pair onto bus as address.
// R9: increment-skip target replaces low byte only, page of next instruction.
// R10: fixed stack depth; push when full drops deepest entry silently.
`timescale 1ns/1ps
`include "sas_consts.vh"
module sas_sequencer #(
    parameter DEPTH = 3
) (
    // clocking
    input  wire        clk,
    input  wire        rst,
    input  wire        ce,
    // instruction stream from program rom
    input  wire        instrValid,
    input  wire [7:0]  instrByte,
    input  wire [7:0]  instrSecond,
    // rom data for table fetch
    input  wire        romDataValid,
    input  wire [7:0]  romData,
    // program counter and rom request
    output reg  [11:0] pc_q,
    output reg         romReq_q,
    output reg  [11:0] romAddr_q,
    // bus address send
    output reg         sendValid_q,
    output reg  [7:0]  sendAddr_q,
    // register file view and table fetch busy flag
    output reg  [7:0]  pairZero_q,
    output reg         busy_q
);
    localparam ST_RUN   = 2'b01;
    localparam ST_FETCH = 2'b10;

    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [3:0]  regs_q [0:15];
    reg  [11:0] nextPc_d;
    reg  [11:0] top_q;
    reg  [2:0]  fetchPair_q;
    reg         regWrEn_d;
    reg  [3:0]  regWrAddr_d;
    reg  [3:0]  regWrData_d;
    reg         pairWrEn_d;
    reg  [2:0]  pairWrSel_d;
    reg  [7:0]  pairWrData_d;
    wire [11:0] entries [0:DEPTH];
    wire [3:0]  opr     = instrByte[`SAS_OPR_MSB:`SAS_OPR_LSB];
    wire [3:0]  opa     = instrByte[`SAS_OPA_MSB:`SAS_OPA_LSB];
    wire [11:0] pcInc1  = pc_q + 12'h001;
    wire [11:0] pcInc2  = pc_q + 12'h002;
    wire [3:0]  incVal  = regs_q[opa] + 4'h1;
    wire        run     = ce && (state_q == ST_RUN) && instrValid;
    wire        isCall  = run && (opr == `SAS_OPR_CALL);
    wire        isRet   = run && (opr == `SAS_OPR_RETURN);
    wire        isIsz   = run && (opr == `SAS_OPR_INC_SKIP);
    wire        isPair  = (opr == `SAS_OPR_PAIR) && opa[`SAS_PAIR_SEL_BIT];
    wire        isSend  = run && isPair;
    wire        isFetch = run && (opr == `SAS_OPR_FETCH) && !opa[`SAS_PAIR_SEL_BIT];
    wire        romDone = (state_q == ST_FETCH) && romDataValid;
    integer     i;

    // level zero is the top entry, so a push moves it one level down
    assign entries[0]     = top_q;                                         // R1
    assign entries[DEPTH] = `SAS_STACK_RESET;

    genvar g;
    generate
        for (g = 1; g <= DEPTH - 1; g = g + 1) begin : gLevel
            // deepest entry falls off the bottom on push; R10
            sas_stack_level #(.AW(12)) uLevel (
                .clk       (clk),
                .rst       (rst),
                .ce        (ce),
                .push      (isCall),                                       // R1
                .pop       (isRet),                                        // R4
                .fromAbove (entries[g-1]),                                 // R1
                .fromBelow (entries[g+1]),
                .entry_q   (entries[g])
            );
        end
    endgenerate

    // top level held separately so a return reads it directly
    always @(posedge clk) begin
        if (rst) begin
            top_q <= `SAS_STACK_RESET;
        end else if (isCall) begin
            top_q <= pcInc2;                                               // R1 R2 R3
        end else if (isRet) begin
            top_q <= (DEPTH > 1) ? entries[1] : `SAS_STACK_RESET;          // R4
        end
    end

    always @* begin
        nextPc_d = pcInc1;
        if (isCall) begin
            nextPc_d = {opa, instrSecond};                                 // R3
        end else if (isRet) begin
            nextPc_d = top_q;                                              // R4
        end else if (isIsz) begin
            if (incVal != 4'h0) begin
                nextPc_d = {pcInc2[`SAS_PAGE_MSB:`SAS_PAGE_LSB], instrSecond}; // R7 R9
            end else begin
                nextPc_d = pcInc2;                                         // R7
            end
        end
    end

    // next state: a table fetch parks the sequencer until the rom answers
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_RUN: begin
                if (isFetch) begin
                    state_d = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (romDone) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    // register file write port: one nibble for increment-skip, a pair for fetch
    always @* begin
        regWrEn_d    = 1'b0;
        regWrAddr_d  = opa;
        regWrData_d  = incVal;
        pairWrEn_d   = 1'b0;
        pairWrSel_d  = fetchPair_q;
        pairWrData_d = romData;
        if (isIsz) begin
            regWrEn_d = 1'b1;                                              // R7
        end
        if (romDone) begin
            pairWrEn_d = 1'b1;                                             // R5
        end
    end

    // register file
    always @(posedge clk) begin
        if (rst) begin
            for (i = 0; i < 16; i = i + 1) begin
                regs_q[i] <= `SAS_REG_RESET;
            end
        end else if (ce) begin
            if (regWrEn_d) begin
                regs_q[regWrAddr_d] <= regWrData_d;                        // R7
            end
            if (pairWrEn_d) begin
                regs_q[{pairWrSel_d, 1'b0}] <= pairWrData_d[7:4];          // R5
                regs_q[{pairWrSel_d, 1'b1}] <= pairWrData_d[3:0];          // R5
            end
        end
    end

    // program counter and sequencer state
    always @(posedge clk) begin
        if (rst) begin
            state_q <= ST_RUN;
            pc_q    <= `SAS_PC_RESET;
            busy_q  <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            busy_q  <= (state_d == ST_FETCH);
            if (run) begin
                pc_q <= nextPc_d;                                          // R3 R4 R7
            end
        end
    end

    // table fetch request; the destination pair is kept until the data arrives
    always @(posedge clk) begin
        if (rst) begin
            romReq_q    <= 1'b0;
            romAddr_q   <= `SAS_PC_RESET;
            fetchPair_q <= 3'h0;
        end else if (ce) begin
            romReq_q <= isFetch;                                           // R5
            if (isFetch) begin
                romAddr_q   <= {pc_q[`SAS_PAGE_MSB:`SAS_PAGE_LSB],
                                regs_q[0], regs_q[1]};                     // R5 R6
                fetchPair_q <= opa[3:1];
            end
        end
    end

    // address send toward the ram and port chips
    always @(posedge clk) begin
        if (rst) begin
            sendValid_q <= 1'b0;
            sendAddr_q  <= 8'h00;
        end else if (ce) begin
            sendValid_q <= isSend;                                         // R8
            if (isSend) begin
                sendAddr_q <= {regs_q[{opa[3:1], 1'b0}],
                               regs_q[{opa[3:1], 1'b1}]};                  // R8
            end
        end
    end

    // view of pair zero, one cycle behind the register file
    always @(posedge clk) begin
        if (rst) begin
            pairZero_q <= 8'h00;
        end else if (ce) begin
            pairZero_q <= {regs_q[0], regs_q[1]};
        end
    end
endmodule

// ===== design/sas_consts.vh
`ifndef SAS_CONSTS_VH
`define SAS_CONSTS_VH
// instruction word fields (8-bit first byte: opr in [7:4], opa in [3:0])
`define SAS_OPR_MSB       7
`define SAS_OPR_LSB       4
`define SAS_OPA_MSB       3
`define SAS_OPA_LSB       0
// operation codes seen on the opr field
`define SAS_OPR_INC_SKIP  4'h7
`define SAS_OPR_CALL      4'h5
`define SAS_OPR_RETURN    4'hC
`define SAS_OPR_PAIR      4'h2
`define SAS_OPR_FETCH     4'h3
// opa bit 0 selects between the two pair operations
`define SAS_PAIR_SEL_BIT  0
// address layout: chip select in [11:8], byte within chip in [7:0]
`define SAS_PAGE_MSB      11
`define SAS_PAGE_LSB      8
`define SAS_BYTE_MSB      7
`define SAS_BYTE_LSB      0
// reset values
`define SAS_PC_RESET      12'h000
`define SAS_STACK_RESET   12'h000
`define SAS_REG_RESET     4'h0
`endif

// ===== design/sas_stack_level.v
`timescale 1ns/1ps
module sas_stack_level #(
    parameter AW = 12
) (
    // clocking
    input  wire          clk,
    input  wire          rst,
    input  wire          ce,
    // shift control
    input  wire          push,
    input  wire          pop,
    input  wire [AW-1:0] fromAbove,
    input  wire [AW-1:0] fromBelow,
    // stored entry
    output reg  [AW-1:0] entry_q
);
    always @(posedge clk) begin
        if (rst) begin
            entry_q <= {AW{1'b0}};
        end else if (ce) begin
            if (push) begin
                entry_q <= fromAbove;
            end else if (pop) begin
                entry_q <= fromBelow;
            end
        end
    end
endmodule

// ===== test/sas_checker.sv
`timescale 1ns/1ps
module sas_checker (
    // clocking
    input wire        clk,
    input wire        rst,
    input wire        ce,
    // inputs
    input wire        instrValid,
    input wire [7:0]  instrByte,
    input wire [7:0]  instrSecond,
    input wire        romDataValid,
    input wire [7:0]  romData,
    // outputs
    input wire [11:0] pc_q,
    input wire        romReq_q,
    input wire [11:0] romAddr_q,
    input wire        sendValid_q,
    input wire [7:0]  sendAddr_q,
    input wire [7:0]  pairZero_q,
    input wire        busy_q
);
    wire        take  = ce && instrValid && !busy_q;
    wire [3:0]  op    = instrByte[7:4];
    wire        takeF = take && op == 4'h3 && !instrByte[0];
    wire        takeS = take && op == 4'h2 && instrByte[0];
    wire [11:0] nxt   = pc_q + 12'h002;
    reg  [2:0]  fetchDst = 3'h0;
    always @(posedge clk) begin
        if (takeF) begin
            fetchDst <= instrByte[3:1];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence dataTaken; ce && busy_q && romDataValid; endsequence
    sequence pairZeroLoad; ce && busy_q && romDataValid && fetchDst == 3'h0 ##1 ce; endsequence
    a_call_target: assert property (
        take && op == 4'h5 |=> pc_q == {$past(instrByte[3:0]), $past(instrSecond)})
        else $error("call target");
    a_skip_page: assert property (
        take && op == 4'h7 |=> pc_q[11:8] == $past(nxt[11:8])
        && (pc_q[7:0] == $past(instrSecond) || pc_q == $past(nxt))) else $error("skip");
    a_fetch_page: assert property (
        takeF |=> romReq_q && busy_q && romAddr_q[11:8] == $past(pc_q[11:8]))
        else $error("fetch page");
    a_req_cause: assert property (
        romReq_q |-> $past(takeF) || $past(!ce && romReq_q)) else $error("stray request");
    a_send_cause: assert property (
        sendValid_q |-> $past(takeS) || $past(!ce && sendValid_q)) else $error("stray send");
    a_send_resp: assert property (
        takeS |=> sendValid_q) else $error("send missing");
    a_busy_end: assert property (
        dataTaken |=> !busy_q) else $error("busy stuck");
    a_busy_hold: assert property (
        busy_q && !romDataValid |=> busy_q) else $error("busy dropped");
    a_pair_load: assert property (
        pairZeroLoad |=> pairZero_q == $past(romData, 2)) else $error("pair");
endmodule

// ===== test/sas_rom_model.sv
`timescale 1ns/1ps
module sas_rom_model #(
    parameter LAT = 2
) (
    // clocking
    input wire        clk,
    // request
    input wire        romReq_q,
    input wire [11:0] romAddr_q,
    // answer
    output reg        romDataValid = 1'b0,
    output reg  [7:0] romData = 8'h00
);
    integer cnt = 0;
    // table byte is the inverted low address; idle bus toggles
    always @(posedge clk) begin
        cnt <= romReq_q ? LAT : (cnt > 0 ? cnt - 1 : 0);
        romDataValid <= (cnt == 1);
        romData <= (cnt == 1) ? ~romAddr_q[7:0] : ~romData;
    end
endmodule

// ===== test/subroutine_address_stack_bench.sv
`timescale 1ns/1ps
module subroutine_address_stack_bench;
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         ce = 1'b1;
    reg         instrValid = 1'b0;
    reg  [15:0] ins = 16'h0000;
    wire        romDataValid, romReq_q, sendValid_q, busy_q;
    wire [7:0]  romData, sendAddr_q, pairZero_q;
    wire [11:0] pc_q, romAddr_q;
    integer     fail_count = 0;
    integer     checks = 0;
    integer     cyc = 0;
    integer     i, n;
    reg  [27:0] rows [0:11];
    always #4 clk = ~clk;
    sas_sequencer #(.DEPTH(3)) i_dut (.clk(clk), .rst(rst), .ce(ce),
        .instrValid(instrValid), .instrByte(ins[15:8]), .instrSecond(ins[7:0]),
        .romDataValid(romDataValid), .romData(romData), .pc_q(pc_q),
        .romReq_q(romReq_q), .romAddr_q(romAddr_q), .sendValid_q(sendValid_q),
        .sendAddr_q(sendAddr_q), .pairZero_q(pairZero_q), .busy_q(busy_q));
    sas_rom_model i_rom (.clk(clk), .romReq_q(romReq_q), .romAddr_q(romAddr_q),
        .romDataValid(romDataValid), .romData(romData));
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", checks, fail_count);
            if (fail_count == 0 && checks > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task cmp(input [11:0] got, input [11:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task step(input [15:0] v);
        begin
            @(posedge clk);
            instrValid <= 1'b1;
            ins <= v;
            @(posedge clk);
            instrValid <= 1'b0;
            #1;
            for (n = 0; n < 20 && busy_q !== 1'b0; n = n + 1) begin
                @(posedge clk);
                #1;
            end
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            fail_count = fail_count + 1;
            stop_test;
        end
    end
    initial begin
        rows[0] = {16'h5A34, 12'hA34};
        rows[1] = {16'h5100, 12'h100};
        rows[2] = {16'h5200, 12'h200};
        rows[3] = {16'h5300, 12'h300};
        rows[4] = {16'hC000, 12'h202};
        rows[5] = {16'hC000, 12'h102};
        rows[6] = {16'hC000, 12'hA36};
        rows[7] = {16'hC000, 12'h000};
        rows[8] = {16'h7055, 12'h055};
        rows[9] = {16'h3000, 12'h056};
        rows[10] = {16'h7199, 12'h058};
        rows[11] = {16'h2100, 12'h059};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        cmp(pc_q, 12'h000);
        for (i = 0; i < 12; i = i + 1) begin
            step(rows[i][27:12]);
            cmp(pc_q, rows[i][11:0]);
            $display("row %0d done", i);
        end
        cmp(romAddr_q, 12'h010);
        cmp({4'h0, pairZero_q}, 12'h0E0);
        cmp({4'h0, sendAddr_q}, 12'h0E0);
        step(16'h5F12);
        cmp(pc_q, 12'hF12);
        $display("call before reset done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        cmp(pc_q, 12'h000);
        $display("reset test done");
        @(posedge clk);
        ce <= 1'b0;
        step(16'h5123);
        cmp(pc_q, 12'h000);
        @(posedge clk);
        ce <= 1'b1;
        $display("freeze test done");
        step(16'hC000);
        cmp(pc_q, 12'h000);
        $display("return after reset done");
        stop_test;
    end
endmodule
bind sas_sequencer sas_checker i_chk (.clk(clk), .rst(rst), .ce(ce),
    .instrValid(instrValid), .instrByte(instrByte), .instrSecond(instrSecond),
    .romDataValid(romDataValid), .romData(romData), .pc_q(pc_q), .romReq_q(romReq_q),
    .romAddr_q(romAddr_q), .sendValid_q(sendValid_q), .sendAddr_q(sendAddr_q),
    .pairZero_q(pairZero_q), .busy_q(busy_q));
